// [src/paegs_cfg.svh]
// Offsets, field positions, reset values, revision and error flag count of the status block
`ifndef PAEGS_CFG_SVH
`define PAEGS_CFG_SVH
`define PAEGS_ADDR_W          8
`define PAEGS_OFS_STATUS      8'h70
`define PAEGS_OFS_CONTROL     8'h00
`define PAEGS_OFS_AUXMODE     8'h74
`define PAEGS_OFS_RAWIN       8'h78
`define PAEGS_BIT_DUPLEX      0
`define PAEGS_BIT_SPEED       1
`define PAEGS_BIT_FORCE       2
`define PAEGS_BIT_ANEG        3
`define PAEGS_BIT_REPEATER    4
`define PAEGS_BIT_REV_LO      5
`define PAEGS_BIT_POL         8
`define PAEGS_BIT_EOF         9
`define PAEGS_BIT_MANCH       10
`define PAEGS_CTL_ANEG_BIT    12
`define PAEGS_CTL_SPEED_BIT   13
`define PAEGS_AUX_ANEG_BIT    15
`define PAEGS_CTL_RESET       16'h3000
`define PAEGS_REVISION        3'h5
`define PAEGS_ERR_FLAGS       2
`endif

// [src/paegs_pkg.sv]
// Types shared by the status block
package paegs_pkg;
    typedef enum logic [0:0] {PAEGS_IDLE, PAEGS_ACK} paegs_bus_state_type;
    typedef logic [15:0] paegs_word_type;
endpackage : paegs_pkg

// [src/paegs_sync.sv]
// Two flip-flop synchroniser for the pin inputs
`timescale 1ns/1ns
module paegs_sync
#(
    parameter int WIDTH = 1
)
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Data
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] q_next;

    always_comb
    begin
        meta_next = d_i;
        q_next    = meta_reg;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_reg <= '0;
            q_reg    <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            q_reg    <= q_next;
        end
    end

    assign q_o = q_reg;
endmodule : paegs_sync

// [src/paegs_top.sv]
// Auxiliary error and general status register with Wishbone slave
//
// Implementation choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`include "paegs_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
// Contract
// (R1) Error flags set on their event, held until the register is read or reset.
// (R2) Receive error output is high in the cycle an error event occurs.
// (R3) Bit 0 reads one while full duplex is active.
// (R4) Bit 1 reads one for 100BASE-X, zero for 10BASE-T.
// (R5) During negotiation exchange speed reports 10BASE-T.
// (R6) Bit 2 zero when both pins low or control bits 12,13 zero.
// (R7) Bit 3 one only with control bit 12 and negotiation pin high.
// (R8) Auxiliary mode bit 15 zero while negotiation disabled, else one.
// (R9) Bit 4 mirrors the repeater select pin.
// (R10) Bits 7:5 return the fixed silicon revision.
// (R11) Bit 8 reads one while receive polarity is inverted, no data error.
// (R12) Bit 9 latches on improper end of frame, 10BASE-T only.
// (R13) Bit 10 latches on Manchester violation, 10BASE-T only.
// (R14) Bits 15:11 read zero; writes to the status register do nothing.
module paegs_top
    import paegs_pkg::*;
#(
    parameter logic [2:0] REVISION = `PAEGS_REVISION // Arbitrary value
)
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Pins
    input  wire logic        negotiation_enable_pin_i,
    input  wire logic        force_fast_speed_pin_i,
    input  wire logic        repeater_select_pin_i,
    // PHY core status, same clock
    input  wire logic        full_duplex_i,
    input  wire logic        speed_fast_i,
    input  wire logic        aneg_busy_i,
    input  wire logic        polarity_inverted_i,
    input  wire logic        eof_error_i,
    input  wire logic        manchester_error_i,
    // Outputs to PHY core
    output logic             receive_error_o,
    output logic             aneg_enabled_o
);
    ////////////////////////////////////////////////////////////////////////////
    logic [2:0] pins_sync;
    logic       aneg_pin;
    logic       fast_pin;
    logic       repeater_pin;

    paegs_sync #(.WIDTH(3)) u_sync
    (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({repeater_select_pin_i, force_fast_speed_pin_i,
                 negotiation_enable_pin_i}),
        .q_o   (pins_sync)
    );
    assign aneg_pin = pins_sync[0];
    assign fast_pin = pins_sync[1];
    assign repeater_pin = pins_sync[2];

    ////////////////////////////////////////////////////////////////////////////
    paegs_bus_state_type state_reg;
    paegs_bus_state_type state_next;
    paegs_word_type      ctl_reg;
    paegs_word_type      ctl_next;
    logic [`PAEGS_ERR_FLAGS-1:0] err_reg;
    logic [`PAEGS_ERR_FLAGS-1:0] err_next;
    logic [31:0]         dat_reg;
    logic [31:0]         dat_next;
    paegs_word_type      status_word;
    logic                aneg_on;
    logic                slow_mode;
    logic [`PAEGS_ERR_FLAGS-1:0] err_event;
    logic                req;
    logic                status_read;

    assign req         = cyc_i && stb_i && (state_reg == PAEGS_IDLE);
    assign status_read = req && !we_i && (adr_i == `PAEGS_OFS_STATUS);
    assign aneg_on     = ctl_reg[`PAEGS_CTL_ANEG_BIT] && aneg_pin; // [R7]
    // Negotiation exchange always runs at 10BASE-T
    assign slow_mode   = !speed_fast_i || aneg_busy_i; // [R5]
    // Error events only count in 10BASE-T operation
    assign err_event   = {manchester_error_i, eof_error_i} & {2{slow_mode}}; // [R12] [R13]

    always_comb
    begin
        status_word = '0; // [R14]
        status_word[`PAEGS_BIT_DUPLEX] = full_duplex_i; // [R3]
        status_word[`PAEGS_BIT_SPEED]  = !slow_mode; // [R4] [R5]
        status_word[`PAEGS_BIT_FORCE]  = !((!aneg_pin && !fast_pin) ||
            (!ctl_reg[`PAEGS_CTL_ANEG_BIT] && !ctl_reg[`PAEGS_CTL_SPEED_BIT])); // [R6]
        status_word[`PAEGS_BIT_ANEG]   = aneg_on; // [R7]
        status_word[`PAEGS_BIT_REPEATER] = repeater_pin; // [R9]
        status_word[`PAEGS_BIT_REV_LO +: 3] = REVISION; // [R10]
        status_word[`PAEGS_BIT_POL]    = polarity_inverted_i; // [R11]
        status_word[`PAEGS_BIT_EOF]    = err_reg[0]; // [R12]
        status_word[`PAEGS_BIT_MANCH]  = err_reg[1]; // [R13]
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        state_next = (state_reg == PAEGS_ACK) ? PAEGS_IDLE : state_next_f();
        ctl_next   = ctl_reg;
        dat_next   = dat_reg;
        if (req && we_i && adr_i == `PAEGS_OFS_CONTROL)
        begin
            if (sel_i[0])
                ctl_next[7:0] = dat_i[7:0];
            if (sel_i[1])
                ctl_next[15:8] = dat_i[15:8];
        end
        if (req && !we_i)
        begin
            case (adr_i)
                `PAEGS_OFS_STATUS:  dat_next = {16'h0000, status_word};
                `PAEGS_OFS_CONTROL: dat_next = {16'h0000, ctl_reg};
                `PAEGS_OFS_AUXMODE: dat_next = {16'h0000, aneg_on, 15'h0000}; // [R8]
                `PAEGS_OFS_RAWIN:   dat_next = {29'h0, repeater_pin, fast_pin, aneg_pin};
                default:            dat_next = 32'h0000_0000;
            endcase
        end
    end

    function automatic paegs_bus_state_type state_next_f();
        return req ? PAEGS_ACK : PAEGS_IDLE;
    endfunction : state_next_f

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= PAEGS_IDLE;
            ctl_reg   <= `PAEGS_CTL_RESET;
            dat_reg   <= 32'h0000_0000;
        end
        else
        begin
            state_reg <= state_next;
            ctl_reg   <= ctl_next;
            dat_reg   <= dat_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One latched flag per error source; read clears, a same-cycle event survives
    for (genvar f = 0; f < `PAEGS_ERR_FLAGS; f++)
    begin : g_flag
        always_comb
        begin
            err_next[f] = (status_read ? 1'b0 : err_reg[f]) | err_event[f]; // [R1]
        end

        always_ff @(posedge clk_i)
        begin
            if (rst_i)
                err_reg[f] <= 1'b0;
            else
                err_reg[f] <= err_next[f];
        end
    end

    // Combinational so the error pulse lands in the error cycle itself, not a clock late
    assign receive_error_o = |err_event; // [R2]
    assign ack_o           = (state_reg == PAEGS_ACK);
    assign dat_o           = dat_reg;
    assign aneg_enabled_o  = aneg_on; // [R7]

    ////////////////////////////////////////////////////////////////////////////
    property p_flag_set;
        @(posedge clk_i) disable iff (rst_i)
        eof_error_i && slow_mode |=> err_reg[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("eof flag not set"); // [R1]

    property p_flag_hold;
        @(posedge clk_i) disable iff (rst_i)
        err_reg[1] && !status_read |=> err_reg[1];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost"); // [R13]

    property p_read_clear;
        @(posedge clk_i) disable iff (rst_i)
        status_read && !err_event[0] |=> !err_reg[0];
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("flag not cleared"); // [R12]

    property p_rxer;
        @(posedge clk_i) disable iff (rst_i)
        (|err_event) |-> receive_error_o;
    endproperty
    a_rxer: assert property (p_rxer) else $error("rxer missing"); // [R2]

    property p_speed;
        @(posedge clk_i) disable iff (rst_i)
        aneg_busy_i |-> !status_word[`PAEGS_BIT_SPEED];
    endproperty
    a_speed: assert property (p_speed) else $error("speed during aneg"); // [R5]

    property p_aneg;
        @(posedge clk_i) disable iff (rst_i)
        status_word[`PAEGS_BIT_ANEG] |-> ctl_reg[12] && aneg_pin;
    endproperty
    a_aneg: assert property (p_aneg) else $error("aneg bit wrong"); // [R7]

    property p_high_zero;
        @(posedge clk_i) disable iff (rst_i)
        status_read |=> dat_o[31:11] == 21'h0 && dat_o[7:5] == REVISION;
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("fixed bits wrong"); // [R14]

    property p_ack;
        @(posedge clk_i) disable iff (rst_i)
        req |=> ack_o ##1 !ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing");

    property p_set_wins;
        @(posedge clk_i) disable iff (rst_i)
        status_read && err_event[1] |=> err_reg[1];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("read clear beat event"); // [R1]

    property p_eof_hold;
        @(posedge clk_i) disable iff (rst_i)
        err_reg[0] && !status_read |=> err_reg[0];
    endproperty
    a_eof_hold: assert property (p_eof_hold) else $error("eof flag lost"); // [R12]

    property p_manch_set;
        @(posedge clk_i) disable iff (rst_i)
        manchester_error_i && slow_mode |=> err_reg[1];
    endproperty
    a_manch_set: assert property (p_manch_set) else $error("code flag not set"); // [R13]

    property p_fast_quiet;
        @(posedge clk_i) disable iff (rst_i)
        !slow_mode && err_reg == 2'h0 |=> err_reg == 2'h0;
    endproperty
    a_fast_quiet: assert property (p_fast_quiet) else $error("flag set at fast speed"); // [R12] [R13]

    property p_rxer_quiet;
        @(posedge clk_i) disable iff (rst_i)
        !(|err_event) |-> !receive_error_o;
    endproperty
    a_rxer_quiet: assert property (p_rxer_quiet) else $error("rxer without event"); // [R2]

    property p_revision;
        @(posedge clk_i) disable iff (rst_i)
        status_read |=> dat_o[7:5] == REVISION;
    endproperty
    a_revision: assert property (p_revision) else $error("revision wrong"); // [R10]

    property p_duplex;
        @(posedge clk_i) disable iff (rst_i)
        status_read |=> dat_o[0] == $past(full_duplex_i);
    endproperty
    a_duplex: assert property (p_duplex) else $error("duplex bit wrong"); // [R3]

    property p_speed_read;
        @(posedge clk_i) disable iff (rst_i)
        status_read |=> dat_o[1] == ($past(speed_fast_i) && !$past(aneg_busy_i));
    endproperty
    a_speed_read: assert property (p_speed_read) else $error("speed bit wrong"); // [R4]

    property p_repeater;
        @(posedge clk_i) disable iff (rst_i)
        status_read |=> dat_o[4] == $past(repeater_pin);
    endproperty
    a_repeater: assert property (p_repeater) else $error("repeater bit wrong"); // [R9]

    property p_polarity;
        @(posedge clk_i) disable iff (rst_i)
        status_read |=> dat_o[8] == $past(polarity_inverted_i);
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity bit wrong"); // [R11]

    property p_force;
        @(posedge clk_i) disable iff (rst_i)
        status_read && !aneg_pin && !fast_pin |=> !dat_o[2];
    endproperty
    a_force: assert property (p_force) else $error("force bit wrong"); // [R6]

    property p_auxmode;
        @(posedge clk_i) disable iff (rst_i)
        req && !we_i && adr_i == `PAEGS_OFS_AUXMODE |=> dat_o[15] == $past(aneg_on);
    endproperty
    a_auxmode: assert property (p_auxmode) else $error("aux mode bit wrong"); // [R8]

    property p_wr_ignore;
        @(posedge clk_i) disable iff (rst_i)
        req && we_i && adr_i != `PAEGS_OFS_CONTROL |=> $stable(ctl_reg);
    endproperty
    a_wr_ignore: assert property (p_wr_ignore) else $error("stray write landed"); // [R14]

    c_read:  cover property (@(posedge clk_i) status_read);
    c_error: cover property (@(posedge clk_i) err_reg == 2'h3);
    c_race:  cover property (@(posedge clk_i) status_read && |err_event);
    c_fast:  cover property (@(posedge clk_i) !slow_mode && eof_error_i);
    c_aneg:  cover property (@(posedge clk_i) status_read && aneg_on);
endmodule : paegs_top

// [verif/paegs_tb.sv]
// Self-checking bench for the auxiliary error and general status block
`timescale 1ns/1ns
`include "paegs_cfg.svh"
module paegs_tb;
    import paegs_pkg::*;
    localparam logic [2:0] REV = 3'h6; // Arbitrary revision value
    // Clock, reset and bus
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h3;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic        ack_o;
    // Pins and core status
    logic        neg_i = 1'b0;
    logic        fast_pin_i = 1'b0;
    logic        repeater_i = 1'b0;
    logic        fdx_i = 1'b0;
    logic        spd_i = 1'b0;
    logic        busy_i = 1'b0;
    logic        pol_i = 1'b0;
    logic        eof_i = 1'b0;
    logic        man_i = 1'b0;
    logic        receive_error_o;
    logic        aneg_enabled_o;
    int          n_errors = 0;
    int          n_tests = 0;
    paegs_top #(.REVISION(REV)) paegs_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .negotiation_enable_pin_i(neg_i), .force_fast_speed_pin_i(fast_pin_i),
        .repeater_select_pin_i(repeater_i), .full_duplex_i(fdx_i), .speed_fast_i(spd_i),
        .aneg_busy_i(busy_i), .polarity_inverted_i(pol_i), .eof_error_i(eof_i),
        .manchester_error_i(man_i), .receive_error_o(receive_error_o),
        .aneg_enabled_o(aneg_enabled_o));
    always #25 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    // Bounded wait so a missing ack ends the run instead of hanging it
    task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                            output logic [31:0] q);
        int k;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        sel_i <= 4'h3;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        for (k = 0; k < 20 && ack_o !== 1'b1; k++) @(posedge clk_i);
        if (ack_o !== 1'b1)
        begin
            n_errors++;
            $display("[ERR] %0t no bus answer", $time);
            complete_run();
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb_cycle
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        wb_cycle(1'b0, a, 32'h0, q);
        check(q, exp, what);
    endtask : rd_chk
    function automatic logic [31:0] exp_stat(input logic [15:0] ctl, input logic [1:0] err);
        logic [15:0] s;
        s = {5'h00, err, pol_i, REV, repeater_i, ctl[12] & neg_i, 1'b0, spd_i & ~busy_i, fdx_i};
        s[2] = ~((~neg_i & ~fast_pin_i) | (~ctl[12] & ~ctl[13]));
        return {16'h0000, s};
    endfunction : exp_stat
    // Error output is looked at mid-cycle, while the one-cycle event stands
    task automatic pulse(input int e, input logic exp_rx);
        eof_i <= (e == 0);
        man_i <= (e == 1);
        @(negedge clk_i);
        check({31'h0, receive_error_o}, {31'h0, exp_rx}, "rx error in event cycle");
        @(posedge clk_i);
        eof_i <= 1'b0;
        man_i <= 1'b0;
        @(negedge clk_i);
        check({31'h0, receive_error_o}, 32'h0, "rx error after event");
        @(posedge clk_i);
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [15:0] ctl;
        logic [31:0] q;
        logic [31:0] x;
        ctl = 16'h3000;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd_chk(`PAEGS_OFS_CONTROL, 32'h3000, "control reset");
        rd_chk(`PAEGS_OFS_STATUS, exp_stat(ctl, 2'h0), "status reset");
        rd_chk(8'h40, 32'h0, "unmapped read");
        $display("Reset test done");
        // Every pin and duplex combination, other status derived from it, under each setting of control bits 13:12
        for (int c = 0; c < 4; c++)
        begin
            ctl = 16'(c) << 12;
            wb_cycle(1'b1, `PAEGS_OFS_CONTROL, {16'h0, ctl}, q);
            for (int i = 0; i < 16; i++)
            begin
                {fdx_i, repeater_i, fast_pin_i, neg_i} <= 4'(i);
                spd_i <= i[1] ^ i[3];
                busy_i <= i[0] & i[2];
                pol_i <= i[2] ^ i[3];
                repeat (4) @(posedge clk_i);
                x = exp_stat(ctl, 2'h0);
                rd_chk(`PAEGS_OFS_STATUS, x, "live");
                rd_chk(`PAEGS_OFS_RAWIN, {29'h0, repeater_i, fast_pin_i, neg_i}, "raw");
                rd_chk(`PAEGS_OFS_AUXMODE, {16'h0, ctl[12] & neg_i, 15'h0}, "aux mode");
                check({31'h0, aneg_enabled_o}, {31'h0, ctl[12] & neg_i}, "aneg out");
            end
        end
        wb_cycle(1'b1, `PAEGS_OFS_STATUS, 32'hFFFF_FFFF, q);
        rd_chk(`PAEGS_OFS_STATUS, exp_stat(ctl, 2'h0), "status write");
        $display("Live status test done");
        // Error flags in 10BASE-T: set, read once, then cleared
        spd_i <= 1'b0;
        for (int e = 0; e < 2; e++)
        begin
            pulse(e, 1'b1);
            rd_chk(`PAEGS_OFS_STATUS, exp_stat(ctl, 2'(1 << e)), "flag set");
            rd_chk(`PAEGS_OFS_STATUS, exp_stat(ctl, 2'h0), "flag read clear");
        end
        pulse(0, 1'b1);
        pulse(1, 1'b1);
        rd_chk(`PAEGS_OFS_STATUS, exp_stat(ctl, 2'h3), "both flags");
        // At 100BASE-X the events are not counted and give no error pulse
        spd_i <= 1'b1;
        busy_i <= 1'b0;
        pulse(0, 1'b0);
        pulse(1, 1'b0);
        rd_chk(`PAEGS_OFS_STATUS, exp_stat(ctl, 2'h0), "fast no flag");
        // Mid-run reset must restore control and clear a pending flag
        wb_cycle(1'b1, `PAEGS_OFS_CONTROL, 32'h0, q);
        spd_i <= 1'b0;
        pulse(1, 1'b1);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        ctl = 16'h3000;
        rd_chk(`PAEGS_OFS_CONTROL, 32'h3000, "control after reset");
        rd_chk(`PAEGS_OFS_STATUS, exp_stat(ctl, 2'h0), "flag reset clear");
        $display("Error flag test done");
        complete_run();
    end
endmodule : paegs_tb
